// ### bench/vid_target_mode_control_bench.sv
// vid_target_mode_control_bench: self-checking bench for vtmc_ctrl with the host model.
// assumes 25 MHz clock, soft ramps at 16 cycles/mV, 500-cycle blanking.
`timescale 1ns/1ps
module vid_target_mode_control_bench
	import vtmc_pkg::*;
;
	typedef struct {logic [4:0] code; logic [10:0] mv;} vtmc_row_t;
	logic clk, resetn, pwr_n, light_load, suspend_req, susp_req, drv_n, rg_out, rg_oe;
	logic [4:0] code_bits, code_req;
	logic [10:0] sus_mv, target_mv, ovp_mv;
	logic [3:0] pwm_in, pwm_out;
	vtmc_sense_t sense;
	vtmc_stat_t stat;
	int errors, n_compared;
	// code beside the level it decodes to
	vtmc_row_t rows [4] = '{'{5'h00, 11'h60E}, '{5'h1E, 11'h320}, '{5'h01, 11'h5F5}, '{5'h02, 11'h5DC}};

	vtmc_host_model i_host (.clk(clk), .code_req(code_req), .susp_req(susp_req),
		.voltage_code_bits(code_bits), .suspend_req(suspend_req));
	vtmc_ctrl i_dut (.clk(clk), .resetn(resetn), .power_off_input_n(pwr_n), .suspend_req(suspend_req),
		.light_load_sel(light_load), .voltage_code_bits(code_bits), .suspend_level_input(sus_mv),
		.sense(sense), .pwm_in(pwm_in), .target_mv(target_mv), .ovp_level_mv(ovp_mv),
		.driver_diode_emulation_n(drv_n), .pwm_out(pwm_out), .regulation_good_out(rg_out),
		.regulation_good_oe(rg_oe), .stat(stat));

	task automatic check(input string name, input logic [10:0] seen, input logic [10:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask : check

	task automatic end_of_test;
		$display("compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : end_of_test

	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask : idle

	// bounded wait for the slewed target to land
	task automatic wait_tgt(input logic [10:0] exp, input int bound);
		int i;
		for (i = 0; i < bound; i++) begin
			@(negedge clk);
			if (target_mv === exp) break;
		end
		if (i == bound) begin
			errors++;
			$display("unexpected target timeout: expected %h", exp);
			end_of_test();
		end
	endtask : wait_tgt

	// posted after a rising edge so the host model latches it cleanly
	task automatic host(input logic [4:0] c, input logic s);
		@(posedge clk);
		code_req = c;
		susp_req = s;
		idle(2);
	endtask : host

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial begin
		resetn = 1'b0;
		pwr_n = 1'b1;
		light_load = 1'b0;
		sus_mv = 11'h3E8;
		sense = '0;
		sense.lower_ok = 1'b1;
		sense.upper_ok = 1'b1;
		pwm_in = 4'hF;
		code_req = 5'h02;
		susp_req = 1'b0;
		errors = 0;
		n_compared = 0;
		idle(5);
		check("target", target_mv, GND_MV);
		check("blanks", 11'({stat.blank_lower, stat.blank_upper, stat.fault, stat.offset_en}), 11'h00C);
		check("oe drv_n", 11'({rg_oe, drv_n}), 11'h001);
		resetn = 1'b1;
		// soft start from ground to the code level
		wait_tgt(11'h5DC, 30000);
		check("target", target_mv, 11'h5DC);
		check("rg_out offset pwm", 11'({rg_out, stat.offset_en, pwm_out}), 11'h01F);
		check("ovp_mv", ovp_mv, 11'h5DC);
		idle(520);
		check("blanks", 11'({stat.blank_lower, stat.blank_upper}), 11'h000);
		sense.lower_ok = 1'b0;
		idle(3);
		check("oe", 11'(rg_oe), 11'h001);
		sense.lower_ok = 1'b1;
		idle(3);
		check("oe", 11'(rg_oe), 11'h000);
		// code transitions, forced PWM
		foreach (rows[i]) begin
			host(rows[i].code, 1'b0);
			idle(1);
			check("blank_lower", 11'({stat.blank_lower, rg_oe}), 11'h002);
			wait_tgt(rows[i].mv, 4000);
			check("target", target_mv, rows[i].mv);
			idle(520);
			check("blanks", 11'({stat.blank_lower, stat.blank_upper}), 11'h000);
		end
		// a new transition during blanking restarts the delay
		host(5'h01, 1'b0);
		wait_tgt(11'h5F5, 4000);
		idle(300);
		host(5'h02, 1'b0);
		wait_tgt(11'h5DC, 4000);
		idle(300);
		check("blank_lower", 11'(stat.blank_lower), 11'h001);
		idle(220);
		check("blank_lower", 11'(stat.blank_lower), 11'h000);
		// suspend with light load low; the code change is ignored
		host(5'h1E, 1'b1);
		check("offset_en", 11'(stat.offset_en), 11'h000);
		wait_tgt(sus_mv, 4000);
		check("target", target_mv, sus_mv);
		idle(400);
		check("skip blanks", 11'({stat.skip, stat.blank_lower, stat.blank_upper}), 11'h003);
		idle(120);
		check("skip mode", 11'({stat.skip, drv_n, stat.blank_lower, stat.blank_upper}), 11'h009);
		check("pwm_out", 11'(pwm_out), 11'h001);
		host(5'h02, 1'b0);
		check("drv_n", 11'(drv_n), 11'h001);
		wait_tgt(11'h5DC, 4000);
		idle(520);
		check("integ_off", 11'(stat.integ_off), 11'h000);
		// light load high: skip at once, then a transition made in skip
		light_load = 1'b1;
		idle(3);
		check("skip", 11'({stat.skip, drv_n, stat.blank_upper}), 11'h005);
		host(5'h04, 1'b0);
		idle(1);
		check("integ ovp", 11'({stat.integ_off, stat.ovp_high}), 11'h003);
		check("ovp_mv", ovp_mv, OVP_SKIP_MV);
		wait_tgt(11'h5AA, 4000);
		idle(520);
		check("integ_off", 11'(stat.integ_off), 11'h001);
		sense.error_cmp = 1'b1;
		idle(4);
		check("integ_off", 11'(stat.integ_off), 11'h000);
		sense.error_cmp = 1'b0;
		light_load = 1'b0;
		idle(520);
		// no-CPU code: soft ramp down, standby, soft ramp back
		host(5'h1F, 1'b0);
		idle(160);
		check("soft down", 11'(target_mv > 11'h595 && target_mv < 11'h5AA), 11'h001);
		wait_tgt(GND_MV, 30000);
		host(5'h02, 1'b0);
		idle(160);
		check("soft up", 11'(target_mv > 11'h000 && target_mv < 11'h014), 11'h001);
		wait_tgt(11'h5DC, 30000);
		// fault latch: set by a trip, held, cleared by power-off only
		sense.undervoltage_trip = 1'b1;
		idle(2);
		check("fault", 11'({stat.fault, pwm_out}), 11'h010);
		check("target", target_mv, GND_MV);
		sense.undervoltage_trip = 1'b0;
		idle(3);
		check("fault", 11'(stat.fault), 11'h001);
		pwr_n = 1'b0;
		idle(2);
		check("off", 11'({stat.fault, stat.blank_lower, rg_oe}), 11'h002);
		pwr_n = 1'b1;
		idle(20);
		sense.thermal_trip = 1'b1;
		idle(2);
		check("fault", 11'(stat.fault), 11'h001);
		end_of_test();
	end
endmodule : vid_target_mode_control_bench

// ### bench/vtmc_host_model.sv
// vtmc_host_model: processor side, drives the voltage code and the suspend request.
// assumes the bench posts requests after a rising edge; outputs move on the falling edge.
`timescale 1ns/1ps
module vtmc_host_model
	import vtmc_pkg::*;
(
	input wire logic clk,
	input wire logic [4:0] code_req,
	input wire logic susp_req,
	output logic [4:0] voltage_code_bits,
	output logic suspend_req
);
	// known values before the first falling edge
	initial begin
		voltage_code_bits = 5'h00;
		suspend_req = 1'b0;
	end
	// one register for all five bits, so they can never skew apart
	always @(negedge clk) begin
		voltage_code_bits <= code_req;
		suspend_req <= susp_req;
	end
endmodule : vtmc_host_model

// ### common/vtmc_pkg.sv
// vtmc_pkg: constants, states and carriers of the voltage target and mode control block.
// assumes a 25 MHz system clock; all levels are in millivolts on 11 bits.
package vtmc_pkg;

	// voltage code decode
	localparam logic [10:0] DAC_TOP_MV = 11'h60E; // 1550 mV at code 00000
	localparam logic [10:0] DAC_STEP_MV = 11'h019; // 25 mV per code step
	localparam logic [4:0] NOCPU_CODE = 5'h1F;
	localparam logic [10:0] GND_MV = 11'h000;
	localparam logic [10:0] OVP_SKIP_MV = 11'h6D6; // 1750 mV trip during skip transitions

	// timing
	localparam int CLK_NS = 40;
	localparam int SLEW_NS_PER_MV = 160; // 6.25 mV/us nominal slew
	localparam int SLEW_CYC = (SLEW_NS_PER_MV + CLK_NS - 1) / CLK_NS;
	localparam int SOFT_FACTOR = 4; // start and shutdown slew at a quarter rate
	localparam int BLANK_US = 20;
	localparam int BLANK_CYC = (BLANK_US * 1000) / CLK_NS;
	localparam logic [4:0] SLEW_LIM = 5'(SLEW_CYC);
	localparam logic [4:0] SOFT_LIM = 5'(SLEW_CYC * SOFT_FACTOR);
	localparam logic [9:0] BLANK_LIM = 10'(BLANK_CYC);

	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_SLEW = 3'b001,
		ST_HOLD = 3'b010,
		ST_RUN = 3'b011,
		ST_FAULT = 3'b100
	} vtmc_state_t;

	// analog comparator results, synchronous to clk
	typedef struct packed {
		logic undervoltage_trip;
		logic thermal_trip;
		logic lower_ok;
		logic upper_ok;
		logic error_cmp;
	} vtmc_sense_t;

	// status flags, from flip-flops except the blank pair, decoded from state_ff and skip_ff
	typedef struct packed {
		logic fault;
		logic skip;
		logic blank_lower;
		logic blank_upper;
		logic ovp_high;
		logic integ_off;
		logic offset_en;
	} vtmc_stat_t;

endpackage : vtmc_pkg

// ### hdl/vtmc_ctrl.sv
// vtmc_ctrl: target selection, slew, blanking, skip mode and fault latch of the regulator.
// assumes all inputs synchronous to clk; the slewed target feeds the analog loop.
//
// What this block does
// - decode code to 1550 mV minus 25 mV per step, down to 800 mV
// - code 11111 ramps to 0 V at soft rate, standby, soft ramp back
// - target is the decoded code, the suspend level or ground
// - suspend ignores code, disables offset, slews to suspend level, overrides all but power-off and fault
// - startup slews up from ground to code or suspend level
// - code change while active starts a transition to the new level
// - suspend entry blanks both thresholds until 20 us after reaching level
// - then with light load low: single-phase skip, skip output low, upper blanked
// - every transition start blanks both power-good thresholds
// - lower threshold back 20 us after settle; upper only in forced PWM
// - skip-mode transitions: trip 1.75 V, integrator off until settled, timed, edge seen
// - undervoltage or thermal trip latches fault, output to ground, until power-off toggles
// - light load high without suspend: skip at once unless the last ramp was soft, upper threshold blanked
// - suspend release with light load low drives skip output high at once, then ramps up
// - in skip keep phase one, hold phases two to four low
`timescale 1ns/1ps
module vtmc_ctrl
	import vtmc_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic power_off_input_n,
	input wire logic suspend_req,
	input wire logic light_load_sel,
	input wire logic [4:0] voltage_code_bits,
	input wire logic [10:0] suspend_level_input,
	input wire vtmc_sense_t sense,
	input wire logic [3:0] pwm_in,
	output logic [10:0] target_mv,
	output logic [10:0] ovp_level_mv,
	output logic driver_diode_emulation_n,
	output logic [3:0] pwm_out,
	output logic regulation_good_out,
	output logic regulation_good_oe,
	output vtmc_stat_t stat
);

	vtmc_state_t state_ff, nxt_state;
	logic [10:0] tgt_ff, nxt_tgt;
	logic [10:0] goal_ff, nxt_goal;
	logic [4:0] slew_cnt_ff, nxt_slew_cnt;
	logic soft_ff, nxt_soft;
	logic skip_ff, nxt_skip;
	logic fault_ff, nxt_fault;
	logic integ_off_ff, nxt_integ_off;
	logic edge_seen_ff, nxt_edge_seen;
	logic err_prev_ff;
	logic [3:0] pwm_ff, nxt_pwm;
	logic pg_oe_ff, nxt_pg_oe;
	logic [10:0] ovp_ff, nxt_ovp;
	logic offset_en_ff, nxt_offset_en;
	logic [10:0] dac_mv;
	logic [10:0] sel_mv;
	logic [4:0] lim;
	logic new_trans;
	logic settled;
	logic tmr_restart;
	logic tmr_done;
	logic blank_lower;
	logic blank_upper;

	// code decode, the processor keeps bit skew short so no debounce here
	assign dac_mv = DAC_TOP_MV - 11'(voltage_code_bits * DAC_STEP_MV);

	// target source select: ground when off or faulted
	always_comb begin
		if (!power_off_input_n || fault_ff || nxt_fault) begin
			sel_mv = GND_MV;
		end else if (suspend_req) begin
			sel_mv = suspend_level_input;
		end else if (voltage_code_bits == NOCPU_CODE) begin
			sel_mv = GND_MV;
		end else begin
			sel_mv = dac_mv;
		end
	end

	// fault latch: only a power-off input or reset clears it
	always_comb begin
		nxt_fault = fault_ff;
		if (!power_off_input_n) begin
			nxt_fault = 1'b0;
		end else if (sense.undervoltage_trip || sense.thermal_trip) begin
			nxt_fault = 1'b1;
		end
	end

	// any change of the selected level is a new transition
	assign new_trans = (sel_mv != goal_ff);
	assign settled = (tgt_ff == goal_ff);
	assign lim = soft_ff ? SOFT_LIM : SLEW_LIM;

	// sequencing state machine
	always_comb begin
		nxt_state = state_ff;
		nxt_goal = sel_mv;
		case (state_ff)
			ST_OFF: begin
				if (power_off_input_n && !nxt_fault && new_trans) begin
					nxt_state = ST_SLEW;
				end
			end
			ST_SLEW: begin
				if (settled && !new_trans) begin
					nxt_state = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (new_trans) begin
					nxt_state = ST_SLEW;
				end else if (tmr_done) begin
					nxt_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (new_trans) begin
					nxt_state = ST_SLEW;
				end
			end
			ST_FAULT: begin
				if (!power_off_input_n) begin
					nxt_state = ST_OFF;
				end
			end
			default: begin
				nxt_state = ST_OFF;
			end
		endcase
		if (nxt_fault) begin
			nxt_state = ST_FAULT;
		end else if (!power_off_input_n) begin
			nxt_state = ST_OFF;
		end
	end

	// slew engine: one millivolt step per period, quarter rate when soft
	always_comb begin
		nxt_tgt = tgt_ff;
		nxt_slew_cnt = slew_cnt_ff;
		nxt_soft = soft_ff;
		if (new_trans) begin
			// soft when starting from ground or heading to it
			nxt_soft = (sel_mv == GND_MV) || (tgt_ff == GND_MV);
			nxt_slew_cnt = 5'h00;
		end
		if (nxt_fault) begin
			nxt_tgt = GND_MV;
			nxt_slew_cnt = 5'h00;
		end else if (!settled && !new_trans) begin
			if (slew_cnt_ff == lim - 5'h01) begin
				nxt_slew_cnt = 5'h00;
				nxt_tgt = (goal_ff > tgt_ff) ? tgt_ff + 11'h001 : tgt_ff - 11'h001;
			end else begin
				nxt_slew_cnt = slew_cnt_ff + 5'h01;
			end
		end
	end

	// blanking delay, restarted on new transitions and at settle
	assign tmr_restart = new_trans || (state_ff == ST_SLEW) || (state_ff == ST_OFF);

	vtmc_timer u_blank_tmr (
		.clk(clk),
		.resetn(resetn),
		.restart(tmr_restart),
		.run(state_ff == ST_HOLD),
		.done(tmr_done)
	);

	// operating mode: forced PWM during soft ramps and when off
	always_comb begin
		nxt_skip = 1'b0;
		if (state_ff == ST_OFF || state_ff == ST_FAULT || nxt_soft) begin
			nxt_skip = 1'b0;
		end else if (light_load_sel) begin
			nxt_skip = 1'b1;
		end else if (suspend_req) begin
			// forced-PWM suspend waits for the settle delay
			nxt_skip = skip_ff || (state_ff == ST_HOLD && tmr_done && goal_ff == suspend_level_input);
		end else begin
			nxt_skip = 1'b0;
		end
	end

	// integrator and trip level during skip-mode transitions
	always_comb begin
		nxt_integ_off = integ_off_ff;
		nxt_edge_seen = edge_seen_ff;
		nxt_ovp = integ_off_ff ? OVP_SKIP_MV : goal_ff;
		if (new_trans) begin
			nxt_integ_off = nxt_skip;
			nxt_edge_seen = 1'b0;
		end else begin
			if (sense.error_cmp != err_prev_ff && state_ff != ST_SLEW) begin
				nxt_edge_seen = 1'b1;
			end
			if ((state_ff == ST_RUN || (state_ff == ST_HOLD && tmr_done)) && edge_seen_ff) begin
				nxt_integ_off = 1'b0;
			end
		end
		if (state_ff == ST_OFF || state_ff == ST_FAULT) begin
			nxt_integ_off = 1'b0;
		end
	end

	// power-good blanking: hi-z while blanked, pulled low when out of window
	assign blank_lower = (state_ff != ST_RUN);
	assign blank_upper = blank_lower || skip_ff;

	always_comb begin
		nxt_pg_oe = 1'b0;
		if (nxt_state == ST_RUN && state_ff == ST_RUN) begin
			nxt_pg_oe = !sense.lower_ok || (!skip_ff && !sense.upper_ok);
		end
		nxt_offset_en = power_off_input_n && !nxt_fault && !suspend_req;
	end

	// phase gating: phase one allowed unless off or faulted, others idle in skip
	always_comb begin
		nxt_pwm = 4'h0;
		if (state_ff != ST_OFF && state_ff != ST_FAULT) begin
			nxt_pwm[0] = pwm_in[0];
			nxt_pwm[3:1] = nxt_skip ? 3'h0 : pwm_in[3:1];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_ff <= ST_OFF;
			tgt_ff <= GND_MV;
			goal_ff <= GND_MV;
			slew_cnt_ff <= 5'h00;
			soft_ff <= 1'b1;
			skip_ff <= 1'b0;
			fault_ff <= 1'b0;
			integ_off_ff <= 1'b0;
			edge_seen_ff <= 1'b0;
			err_prev_ff <= 1'b0;
			pwm_ff <= 4'h0;
			pg_oe_ff <= 1'b0;
			ovp_ff <= GND_MV;
			offset_en_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			tgt_ff <= nxt_tgt;
			goal_ff <= nxt_goal;
			slew_cnt_ff <= nxt_slew_cnt;
			soft_ff <= nxt_soft;
			skip_ff <= nxt_skip;
			fault_ff <= nxt_fault;
			integ_off_ff <= nxt_integ_off;
			edge_seen_ff <= nxt_edge_seen;
			err_prev_ff <= sense.error_cmp;
			pwm_ff <= nxt_pwm;
			pg_oe_ff <= nxt_pg_oe;
			ovp_ff <= nxt_ovp;
			offset_en_ff <= nxt_offset_en;
		end
	end

	// outputs
	assign target_mv = tgt_ff;
	assign ovp_level_mv = ovp_ff;
	assign driver_diode_emulation_n = !skip_ff;
	assign pwm_out = pwm_ff;
	assign regulation_good_out = 1'b0;
	assign regulation_good_oe = pg_oe_ff;
	assign stat = '{fault: fault_ff, skip: skip_ff, blank_lower: blank_lower, blank_upper: blank_upper,
		ovp_high: integ_off_ff, integ_off: integ_off_ff, offset_en: offset_en_ff};

	// checks
	sequence s_active;
		power_off_input_n && !fault_ff && !sense.undervoltage_trip && !sense.thermal_trip;
	endsequence

	property p_code_decode;
		@(posedge clk) disable iff (!resetn)
		s_active ##0 (!suspend_req && voltage_code_bits != NOCPU_CODE)
		|=> goal_ff == DAC_TOP_MV - 11'($past(voltage_code_bits) * DAC_STEP_MV);
	endproperty
	a_code_decode: assert property (p_code_decode) else $error("decoded level wrong");

	property p_nocpu;
		@(posedge clk) disable iff (!resetn)
		s_active ##0 (!suspend_req && voltage_code_bits == NOCPU_CODE) |=> goal_ff == GND_MV && soft_ff;
	endproperty
	a_nocpu: assert property (p_nocpu) else $error("no-cpu code not ramping soft to ground");

	property p_suspend_goal;
		@(posedge clk) disable iff (!resetn)
		s_active ##0 suspend_req |=> goal_ff == $past(suspend_level_input) && !offset_en_ff;
	endproperty
	a_suspend_goal: assert property (p_suspend_goal) else $error("suspend level not selected");

	property p_fault_hold;
		@(posedge clk) disable iff (!resetn)
		fault_ff && power_off_input_n |=> fault_ff && tgt_ff == GND_MV && pwm_out == 4'h0;
	endproperty
	a_fault_hold: assert property (p_fault_hold) else $error("fault latch lost or output not grounded");

	property p_off_clear;
		@(posedge clk) disable iff (!resetn)
		!power_off_input_n |=> !fault_ff && goal_ff == GND_MV && !regulation_good_oe && blank_lower;
	endproperty
	a_off_clear: assert property (p_off_clear) else $error("power-off did not clear and blank");

	property p_trans_blank;
		@(posedge clk) disable iff (!resetn)
		(state_ff == ST_RUN && new_trans) |=> blank_lower && blank_upper ##1 !regulation_good_oe;
	endproperty
	a_trans_blank: assert property (p_trans_blank) else $error("transition not blanked");

	property p_settle_delay;
		@(posedge clk) disable iff (!resetn)
		(state_ff == ST_SLEW ##1 state_ff == ST_HOLD) |-> ##[1:520] (state_ff != ST_HOLD);
	endproperty
	a_settle_delay: assert property (p_settle_delay) else $error("blanking delay overran");

	property p_skip_phases;
		@(posedge clk) disable iff (!resetn)
		skip_ff |-> pwm_out[3:1] == 3'h0 && blank_upper && !driver_diode_emulation_n;
	endproperty
	a_skip_phases: assert property (p_skip_phases) else $error("skip mode drives extra phases");

	property p_sus_release;
		@(posedge clk) disable iff (!resetn)
		$fell(suspend_req) && !light_load_sel |=> driver_diode_emulation_n;
	endproperty
	a_sus_release: assert property (p_sus_release) else $error("skip output not high after suspend");

	property p_light_load;
		@(posedge clk) disable iff (!resetn)
		s_active ##0 (state_ff == ST_RUN && light_load_sel && !soft_ff && !suspend_req && !new_trans) |=> skip_ff;
	endproperty
	a_light_load: assert property (p_light_load) else $error("light load did not enter skip");

	property p_skip_trans;
		@(posedge clk) disable iff (!resetn)
		(nxt_skip && new_trans && state_ff != ST_OFF && !nxt_fault) |=> integ_off_ff ##1 ovp_level_mv == OVP_SKIP_MV;
	endproperty
	a_skip_trans: assert property (p_skip_trans) else $error("skip transition did not raise trip");

endmodule : vtmc_ctrl

// ### hdl/vtmc_timer.sv
// vtmc_timer: restartable blanking delay counter, done stays high until restart.
// assumes restart and run are synchronous to clk.
`timescale 1ns/1ps
module vtmc_timer
	import vtmc_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic restart,
	input wire logic run,
	output logic done
);

	logic [9:0] cnt_ff;
	logic [9:0] nxt_cnt;
	logic done_ff;
	logic nxt_done;

	// restart wins over counting so a new transition always gets a full delay
	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_done = done_ff;
		if (restart) begin
			nxt_cnt = 10'h000;
			nxt_done = 1'b0;
		end else if (run && !done_ff) begin
			if (cnt_ff == BLANK_LIM - 10'h001) begin
				nxt_done = 1'b1;
			end else begin
				nxt_cnt = cnt_ff + 10'h001;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_ff <= 10'h000;
			done_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			done_ff <= nxt_done;
		end
	end

	assign done = done_ff;

endmodule : vtmc_timer
